// ### bench/dvc_debug_status_properties.sv
`timescale 1ns/1ps
module dvc_debug_status_properties (
    // clock and reset
    input wire logic                 clk,
    input wire logic                 rst,
    input wire dvc_pkg::dvc_reset_e  resetKind,
    // register port
    input wire dvc_pkg::dvc_spr_s    spr,
    input wire logic [31:0]          sprReadData,
    input wire logic                 sprReadValid,
    // pipeline
    input wire dvc_pkg::dvc_event_s  events,
    input wire dvc_pkg::dvc_access_s access,
    input wire logic                 exceptionGateBit,
    // results
    input wire logic                 valueMatch1,
    input wire logic                 valueMatch2,
    input wire logic                 debugEventPending
);
    // ------------------------------------------------------------
    // shadow of the compare settings
    // ------------------------------------------------------------
    logic [31:0] ctl;
    logic [31:0] ref1;
    logic [31:0] ref2;
    logic        exp1;
    logic        exp2;
    logic        clrSts;
    logic        mapped;

    function automatic logic hit(input logic [31:0] d, r, input logic [3:0] l,
                                 input logic [1:0] k);
        logic [3:0] e;
        for (int i = 0; i < 4; i++) e[i] = d[8*i+:8] == r[8*i+:8];
        case (k)
            2'h1: hit = (l != 4'h0) && ((e & l) == l);
            2'h2: hit = |(e & l);
            2'h3: hit = (&l[3:2] && &e[3:2]) || (&l[1:0] && &e[1:0]);
            default: hit = 1'b0;
        endcase
    endfunction

    always_ff @(posedge clk) begin
        if (rst) begin
            ctl <= '0;
            ref1 <= '0;
            ref2 <= '0;
        end else if (spr.write) begin
            if (spr.num == dvc_pkg::SPR_CTRL1) ctl <= spr.data & dvc_pkg::CTL_WRITABLE;
            if (spr.num == dvc_pkg::SPR_REF1) ref1 <= spr.data;
            if (spr.num == dvc_pkg::SPR_REF2) ref2 <= spr.data;
        end
    end

    assign exp1 = hit(access.data, ref1, ctl[15:12], ctl[19:18]);
    assign exp2 = hit(access.data, ref2, ctl[11:8], ctl[17:16]);
    assign clrSts = spr.write && spr.num == dvc_pkg::SPR_STATUS;
    assign mapped = spr.num inside {dvc_pkg::SPR_STATUS, dvc_pkg::SPR_CTRL1,
                                    dvc_pkg::SPR_REF1, dvc_pkg::SPR_REF2};

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    a_match_one: assert property (
        !rst |=> valueMatch1 == $past(access.valid && exp1))
        else $error("comparator one result wrong");
    a_match_two: assert property (
        !rst |=> valueMatch2 == $past(access.valid && exp2))
        else $error("comparator two result wrong");
    a_read_answer: assert property (
        spr.read |=> sprReadValid)
        else $error("read not answered next cycle");
    a_read_quiet: assert property (
        !spr.read |=> !sprReadValid && sprReadData == 32'h0000_0000)
        else $error("read data not idle");
    a_unmapped_zero: assert property (
        spr.read && !mapped |=> sprReadData == 32'h0000_0000)
        else $error("unmapped register not zero");
    a_flag_pending: assert property (
        (|events) |=> debugEventPending)
        else $error("event did not raise pending");
    a_flag_sticky: assert property (
        debugEventPending && !clrSts |=> debugEventPending)
        else $error("status flag lost without clear");
    a_data_flag: assert property (
        access.valid && !access.store && access.addrHit1 && ctl[31]
        && ctl[15:12] == 4'h0 |=> debugEventPending)
        else $error("load compare event missed");
endmodule

bind dvc_debug_status dvc_debug_status_properties i_dvc_debug_status_properties (
    .clk(clk), .rst(rst), .resetKind(resetKind), .spr(spr),
    .sprReadData(sprReadData), .sprReadValid(sprReadValid), .events(events),
    .access(access), .exceptionGateBit(exceptionGateBit), .valueMatch1(valueMatch1),
    .valueMatch2(valueMatch2), .debugEventPending(debugEventPending));

// ### bench/dvc_pipe_model.sv
`timescale 1ns/1ps
module dvc_pipe_model (
    // clock
    input wire logic             clk,
    // toward the status block
    output dvc_pkg::dvc_event_s  events,
    output dvc_pkg::dvc_access_s access
);
    initial begin
        events = '0;
        access = '0;
    end

    // one-cycle pulse; released data shows the inverse so no stale match
    task automatic fire(input dvc_pkg::dvc_event_s e, input dvc_pkg::dvc_access_s a);
        @(posedge clk);
        events <= e;
        access <= a;
        @(posedge clk);
        events <= '0;
        access <= {4'h0, ~a.data};
    endtask
endmodule

// ### bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic                 clk;
    logic                 rst;
    dvc_pkg::dvc_reset_e  resetKind;
    dvc_pkg::dvc_spr_s    spr;
    dvc_pkg::dvc_event_s  events;
    dvc_pkg::dvc_access_s access;
    logic                 gate;
    logic                 vm1;
    logic                 vm2;
    logic                 pend;
    logic                 rdValid;
    logic [31:0]          rdData;
    logic [31:0]          q;
    logic                 qValid;
    int                   badCount = 0;
    int                   compares = 0;
    int                   bitOf[9] = '{31, 30, 29, 28, 27, 18, 19, 25, 26};
    logic [31:0]          cCtl[6] = '{32'h0005_FF00, 32'h0004_FF00, 32'h000A_1800,
                                      32'h000F_F300, 32'h000E_3F00, 32'h0005_6000};
    logic [31:0]          cDat[6] = '{32'h1122_3344, 32'h1122_3345, 32'h0000_0044,
                                      32'h1122_7788, 32'h1122_0000, 32'h0022_3300};
    logic [1:0]           cExp[6] = '{2'b10, 2'b00, 2'b10, 2'b11, 2'b00, 2'b10};

    dvc_debug_status #(.DataWidth(32)) i_dvc_debug_status (
        .clk(clk), .rst(rst), .resetKind(resetKind), .spr(spr), .sprReadData(rdData),
        .sprReadValid(rdValid), .events(events), .access(access),
        .exceptionGateBit(gate), .valueMatch1(vm1), .valueMatch2(vm2),
        .debugEventPending(pend));
    dvc_pipe_model i_dvc_pipe_model (.clk(clk), .events(events), .access(access));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            badCount++;
            $display("[FAIL] %s expected %h seen %h", s, exp, seen);
        end
    endtask

    task automatic stopTest();
        $display("compares %0d mismatches %0d", compares, badCount);
        if (badCount == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic acc(input logic r, w, input logic [9:0] n, input logic [31:0] d);
        @(posedge clk);
        spr <= {r, w, n, d};
        @(posedge clk);
        spr <= '0;
        #1 q = rdData;
        qValid = rdValid;
    endtask

    task automatic rdChk(input logic [9:0] n, input logic [31:0] e, input string s);
        acc(1'b1, 1'b0, n, 32'h0000_0000);
        chk(s, q, e);
        chk("readValid", 32'(qValid), 32'h0000_0001);
    endtask

    task automatic doReset(input dvc_pkg::dvc_reset_e k);
        @(posedge clk);
        rst <= 1'b1;
        resetKind <= k;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
    endtask

    initial begin
        #20000;
        badCount++;
        stopTest();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1;
        resetKind = dvc_pkg::DVC_RST_CHIP;
        spr = '0;
        gate = 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rdChk(dvc_pkg::SPR_STATUS, 32'h0000_0200, "resetChip");
        acc(1'b0, 1'b1, dvc_pkg::SPR_STATUS, 32'h0000_0300);
        rdChk(dvc_pkg::SPR_STATUS, 32'h0000_0000, "resetCleared");
        acc(1'b0, 1'b1, dvc_pkg::SPR_CTRL1, 32'hFFFF_FFFF);
        rdChk(dvc_pkg::SPR_CTRL1, 32'hFFCF_FF00, "ctlReserved");
        acc(1'b0, 1'b1, 10'h100, 32'hFFFF_FFFF);
        rdChk(10'h100, 32'h0000_0000, "unmapped");
        for (int i = 0; i < 9; i++) begin
            i_dvc_pipe_model.fire(9'h100 >> i, '0);
            rdChk(dvc_pkg::SPR_STATUS, 32'h1 << bitOf[i], "eventFlag");
            chk("pending", 32'(pend), 32'h0000_0001);
            acc(1'b0, 1'b1, dvc_pkg::SPR_STATUS, 32'h0000_0000);
            rdChk(dvc_pkg::SPR_STATUS, 32'h1 << bitOf[i], "writeZero");
            acc(1'b0, 1'b1, dvc_pkg::SPR_STATUS, 32'h1 << bitOf[i]);
            rdChk(dvc_pkg::SPR_STATUS, 32'h0000_0000, "writeOne");
            chk("pendingClear", 32'(pend), 32'h0000_0000);
        end
        @(posedge clk);
        gate <= 1'b0;
        i_dvc_pipe_model.fire(9'h020, '0);
        rdChk(dvc_pkg::SPR_STATUS, 32'h1010_0000, "imprecise");
        @(posedge clk);
        gate <= 1'b1;
        acc(1'b0, 1'b1, dvc_pkg::SPR_STATUS, 32'h1010_0000);
        // load 1 and store 2 enabled, lanes off so address hit alone counts
        acc(1'b0, 1'b1, dvc_pkg::SPR_CTRL1, 32'h9000_0000);
        i_dvc_pipe_model.fire('0, {4'hB, 32'h0000_0000});
        rdChk(dvc_pkg::SPR_STATUS, 32'h0100_0000, "loadFlag");
        acc(1'b0, 1'b1, dvc_pkg::SPR_STATUS, 32'h0100_0000);
        i_dvc_pipe_model.fire('0, {4'hF, 32'h0000_0000});
        rdChk(dvc_pkg::SPR_STATUS, 32'h0020_0000, "storeFlag");
        acc(1'b0, 1'b1, dvc_pkg::SPR_STATUS, 32'h0020_0000);
        acc(1'b0, 1'b1, dvc_pkg::SPR_REF1, 32'h1122_3344);
        acc(1'b0, 1'b1, dvc_pkg::SPR_REF2, 32'h5566_7788);
        // halfword cases keep lanes at 0011 or 1111
        for (int i = 0; i < 6; i++) begin
            acc(1'b0, 1'b1, dvc_pkg::SPR_CTRL1, cCtl[i]);
            i_dvc_pipe_model.fire('0, {4'h8, cDat[i]});
            #1;
            chk("match1", 32'(vm1), 32'(cExp[i][1]));
            chk("match2", 32'(vm2), 32'(cExp[i][0]));
        end
        doReset(dvc_pkg::DVC_RST_CORE);
        rdChk(dvc_pkg::SPR_STATUS, 32'h0000_0100, "resetCore");
        doReset(dvc_pkg::DVC_RST_SYSTEM);
        rdChk(dvc_pkg::SPR_STATUS, 32'h0000_0300, "resetSystem");
        rdChk(dvc_pkg::SPR_CTRL1, 32'h0000_0000, "ctlAfterReset");
        stopTest();
    end
endmodule

// ### rtl/dvc_debug_status.sv
// Behaviour
// - comparator 1 mode at control bits 12:13
// - comparator 2 mode at bits 14:15
// - AND: all enabled bytes equal reference
// - OR: any enabled byte equals reference
// - AND-OR: either halfword with both lanes enabled equals reference halfword
// - comparator 1 lane enables at bits 16:19
// - comparator 2 lane enables at bits 20:23
// - status bits 0-4 record five event kinds
// - fetch and data compare events in status
// - gated-off event sets imprecise flag bit 11
// - every reset loads its kind into bits 22:23
// - cleared reset field reads 00 until reset
// - separate load and store enables per comparator
`timescale 1ns/1ps
module dvc_debug_status #(
    parameter int DataWidth = 32
) (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire dvc_pkg::dvc_reset_e  resetKind,
    // special-purpose register port
    input  wire dvc_pkg::dvc_spr_s    spr,
    output logic [31:0]               sprReadData,
    output logic                      sprReadValid,
    // pipeline events
    input  wire dvc_pkg::dvc_event_s  events,
    input  wire dvc_pkg::dvc_access_s access,
    input  wire logic                 exceptionGateBit,
    // results
    output logic                      valueMatch1,
    output logic                      valueMatch2,
    output logic                      debugEventPending
);

    if (DataWidth != 32) begin : gChk
        $error("dvc_debug_status serves 32-bit data only");
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [3:0] laneField(input logic [31:0] ctl, input int lo);
        laneField = ctl[lo +: 4];
    endfunction

    function automatic dvc_pkg::dvc_mode_e kindField(input logic [31:0] ctl, input int lo);
        kindField = dvc_pkg::dvc_mode_e'(ctl[lo +: 2]);
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [31:0] debugControlOne;
    logic [31:0] valueMatch1Reference;
    logic [31:0] valueMatch2Reference;
    logic [31:0] debugEventStatus;
    logic [31:0] next_debugControlOne;
    logic [31:0] next_valueMatch1Reference;
    logic [31:0] next_valueMatch2Reference;
    logic [31:0] next_debugEventStatus;
    logic [31:0] next_sprReadData;
    logic        next_sprReadValid;
    logic        next_valueMatch1;
    logic        next_valueMatch2;
    logic        next_debugEventPending;

    logic        rawMatch1;
    logic        rawMatch2;
    logic        dataOk1;
    logic        dataOk2;
    logic [31:0] hits;
    logic [31:0] clearMask;
    logic        anyHit;

    // ------------------------------------------------------------
    // value comparators
    // ------------------------------------------------------------
    dvc_value_compare #(
        .DataWidth (DataWidth)
    ) uCmp1 (
        .data      (access.data),
        .reference (valueMatch1Reference),
        .lanes     (laneField(debugControlOne, dvc_pkg::CTL_LANES1_LO)),
        .kind      (kindField(debugControlOne, dvc_pkg::CTL_KIND1_LO)),
        .match     (rawMatch1)
    );

    dvc_value_compare #(
        .DataWidth (DataWidth)
    ) uCmp2 (
        .data      (access.data),
        .reference (valueMatch2Reference),
        .lanes     (laneField(debugControlOne, dvc_pkg::CTL_LANES2_LO)),
        .kind      (kindField(debugControlOne, dvc_pkg::CTL_KIND2_LO)),
        .match     (rawMatch2)
    );

    // ------------------------------------------------------------
    // event gathering
    // ------------------------------------------------------------
    always_comb begin
        // no lanes enabled means address match alone counts
        dataOk1 = (laneField(debugControlOne, dvc_pkg::CTL_LANES1_LO) == 4'h0) || rawMatch1;
        dataOk2 = (laneField(debugControlOne, dvc_pkg::CTL_LANES2_LO) == 4'h0) || rawMatch2;
        hits = 32'h0000_0000;
        hits[dvc_pkg::STS_COMPLETION] = events.completion;
        hits[dvc_pkg::STS_BRANCH]     = events.branch;
        hits[dvc_pkg::STS_EXCEPTION]  = events.exception;
        hits[dvc_pkg::STS_TRAP]       = events.trap;
        hits[dvc_pkg::STS_UNCOND]     = events.uncond;
        hits[dvc_pkg::STS_FETCH1]     = events.fetch[0];
        hits[dvc_pkg::STS_FETCH2]     = events.fetch[1];
        hits[dvc_pkg::STS_FETCH3]     = events.fetch[2];
        hits[dvc_pkg::STS_FETCH4]     = events.fetch[3];
        hits[dvc_pkg::STS_LOAD1]  = access.valid && !access.store && access.addrHit1
                                    && debugControlOne[dvc_pkg::CTL_LOAD1_EN] && dataOk1;
        hits[dvc_pkg::STS_STORE1] = access.valid && access.store && access.addrHit1
                                    && debugControlOne[dvc_pkg::CTL_STORE1_EN] && dataOk1;
        hits[dvc_pkg::STS_LOAD2]  = access.valid && !access.store && access.addrHit2
                                    && debugControlOne[dvc_pkg::CTL_LOAD2_EN] && dataOk2;
        hits[dvc_pkg::STS_STORE2] = access.valid && access.store && access.addrHit2
                                    && debugControlOne[dvc_pkg::CTL_STORE2_EN] && dataOk2;
        anyHit = |hits;
        // event still recorded; gate closed marks it imprecise
        hits[dvc_pkg::STS_IMPRECISE] = anyHit && !exceptionGateBit;
    end

    // ------------------------------------------------------------
    // register next values
    // ------------------------------------------------------------
    always_comb begin
        next_debugControlOne      = debugControlOne;
        next_valueMatch1Reference = valueMatch1Reference;
        next_valueMatch2Reference = valueMatch2Reference;
        clearMask                 = 32'h0000_0000;

        if (spr.write) begin
            case (spr.num)
                dvc_pkg::SPR_CTRL1: begin
                    next_debugControlOne = spr.data & dvc_pkg::CTL_WRITABLE;
                end
                dvc_pkg::SPR_REF1: begin
                    next_valueMatch1Reference = spr.data;
                end
                dvc_pkg::SPR_REF2: begin
                    next_valueMatch2Reference = spr.data;
                end
                dvc_pkg::SPR_STATUS: begin
                    clearMask = spr.data;
                end
                default: begin
                    clearMask = 32'h0000_0000;
                end
            endcase
        end

        // set beats clear for the same bit in the same cycle
        next_debugEventStatus = ((debugEventStatus & ~clearMask) | hits)
                                & dvc_pkg::STS_FLAGS;
        // reset kind is held until the next reset or a clear
        next_debugEventStatus[dvc_pkg::STS_RESET_LO +: 2] =
            debugEventStatus[dvc_pkg::STS_RESET_LO +: 2]
            & ~clearMask[dvc_pkg::STS_RESET_LO +: 2];

        if (rst) begin
            next_debugControlOne      = dvc_pkg::CTL_RESET;
            next_valueMatch1Reference = 32'h0000_0000;
            next_valueMatch2Reference = 32'h0000_0000;
            next_debugEventStatus     = 32'h0000_0000;
            next_debugEventStatus[dvc_pkg::STS_RESET_LO +: 2] = resetKind;
        end
    end

    // ------------------------------------------------------------
    // read path and result outputs
    // ------------------------------------------------------------
    always_comb begin
        next_sprReadData  = 32'h0000_0000;
        next_sprReadValid = spr.read;
        if (spr.read) begin
            case (spr.num)
                dvc_pkg::SPR_CTRL1:  next_sprReadData = debugControlOne;
                dvc_pkg::SPR_REF1:   next_sprReadData = valueMatch1Reference;
                dvc_pkg::SPR_REF2:   next_sprReadData = valueMatch2Reference;
                dvc_pkg::SPR_STATUS: next_sprReadData = debugEventStatus;
                default:             next_sprReadData = 32'h0000_0000;
            endcase
        end
        next_valueMatch1       = access.valid && rawMatch1;
        next_valueMatch2       = access.valid && rawMatch2;
        next_debugEventPending = |(next_debugEventStatus & dvc_pkg::STS_FLAGS);
        if (rst) begin
            next_sprReadData       = 32'h0000_0000;
            next_sprReadValid      = 1'b0;
            next_valueMatch1       = 1'b0;
            next_valueMatch2       = 1'b0;
            next_debugEventPending = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        debugControlOne      <= next_debugControlOne;
        valueMatch1Reference <= next_valueMatch1Reference;
        valueMatch2Reference <= next_valueMatch2Reference;
        debugEventStatus     <= next_debugEventStatus;
        sprReadData          <= next_sprReadData;
        sprReadValid         <= next_sprReadValid;
        valueMatch1          <= next_valueMatch1;
        valueMatch2          <= next_valueMatch2;
        debugEventPending    <= next_debugEventPending;
    end

endmodule

// ### rtl/dvc_value_compare.sv
`timescale 1ns/1ps
module dvc_value_compare #(
    parameter int DataWidth = 32
) (
    // operands
    input  wire logic [DataWidth-1:0] data,
    input  wire logic [DataWidth-1:0] reference,
    // settings
    input  wire logic [3:0]           lanes,
    input  wire dvc_pkg::dvc_mode_e   kind,
    // result
    output logic                      match
);

    if (DataWidth != 32) begin : gChk
        $error("dvc_value_compare serves 32-bit data only");
    end

    logic [3:0] laneEq;
    logic       upperHit;
    logic       lowerHit;

    always_comb begin
        for (int k = 0; k < 4; k++) begin
            laneEq[k] = (data[8*k +: 8] == reference[8*k +: 8]);
        end
        upperHit = (lanes[3:2] == 2'h3) && (laneEq[3:2] == 2'h3);
        lowerHit = (lanes[1:0] == 2'h3) && (laneEq[1:0] == 2'h3);
        case (kind)
            // no lane enabled never matches
            dvc_pkg::DVC_MODE_AND:   match = (lanes != 4'h0) && ((laneEq & lanes) == lanes);
            dvc_pkg::DVC_MODE_OR:    match = |(laneEq & lanes);
            dvc_pkg::DVC_MODE_ANDOR: match = upperHit || lowerHit;
            default:                 match = 1'b0;
        endcase
    end

endmodule

// ### shared/dvc_pkg.sv
package dvc_pkg;

    // ------------------------------------------------------------
    // special-purpose register numbers
    // ------------------------------------------------------------
    localparam logic [9:0] SPR_STATUS = 10'h3F0;
    localparam logic [9:0] SPR_CTRL1  = 10'h3BD;
    localparam logic [9:0] SPR_REF1   = 10'h3B6;
    localparam logic [9:0] SPR_REF2   = 10'h3B7;

    // ------------------------------------------------------------
    // debug_control_one fields (msb-0 bit n sits at [31-n])
    // ------------------------------------------------------------
    localparam int CTL_LOAD1_EN    = 31;
    localparam int CTL_LOAD2_EN    = 30;
    localparam int CTL_STORE1_EN   = 29;
    localparam int CTL_STORE2_EN   = 28;
    localparam int CTL_KIND1_LO    = 18;
    localparam int CTL_KIND2_LO    = 16;
    localparam int CTL_LANES1_LO   = 12;
    localparam int CTL_LANES2_LO   = 8;
    localparam logic [31:0] CTL_WRITABLE = 32'hFFCF_FF00;
    localparam logic [31:0] CTL_RESET    = 32'h0000_0000;

    // ------------------------------------------------------------
    // debug_event_status fields
    // ------------------------------------------------------------
    localparam int STS_COMPLETION  = 31;
    localparam int STS_BRANCH      = 30;
    localparam int STS_EXCEPTION   = 29;
    localparam int STS_TRAP        = 28;
    localparam int STS_UNCOND      = 27;
    localparam int STS_FETCH1      = 26;
    localparam int STS_FETCH2      = 25;
    localparam int STS_LOAD1       = 24;
    localparam int STS_STORE1      = 23;
    localparam int STS_LOAD2       = 22;
    localparam int STS_STORE2      = 21;
    localparam int STS_IMPRECISE   = 20;
    localparam int STS_FETCH3      = 19;
    localparam int STS_FETCH4      = 18;
    localparam int STS_RESET_LO    = 8;
    localparam logic [31:0] STS_FLAGS = 32'hFFFC_0000;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        DVC_MODE_UNDEF = 2'b00,
        DVC_MODE_AND   = 2'b01,
        DVC_MODE_OR    = 2'b10,
        DVC_MODE_ANDOR = 2'b11
    } dvc_mode_e;

    typedef enum logic [1:0] {
        DVC_RST_NONE   = 2'b00,
        DVC_RST_CORE   = 2'b01,
        DVC_RST_CHIP   = 2'b10,
        DVC_RST_SYSTEM = 2'b11
    } dvc_reset_e;

    typedef struct packed {
        logic        valid;
        logic        store;
        logic        addrHit1;
        logic        addrHit2;
        logic [31:0] data;
    } dvc_access_s;

    typedef struct packed {
        logic       completion;
        logic       branch;
        logic       exception;
        logic       trap;
        logic       uncond;
        logic [3:0] fetch;
    } dvc_event_s;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [9:0]  num;
        logic [31:0] data;
    } dvc_spr_s;

endpackage
